// ### hw/i2c_rate_pkg.sv
// Constants, tables and carrier types for the two-wire rate divider and control block
package i2c_rate_pkg;
   localparam logic [7:0] rate_div_offs = 8'h00;
   localparam logic [7:0] bus_control_offs = 8'h04;
   localparam logic [7:0] status_offs = 8'h08;
   localparam logic [7:0] decode_offs = 8'h0c;
   localparam int ctl_enable_pos = 7;
   localparam int ctl_irq_en_pos = 6;
   localparam int ctl_master_pos = 5;
   localparam int ctl_tx_pos = 4;
   localparam int ctl_ack_pos = 3;
   localparam int ctl_repeat_start_request_pos = 2;
   localparam int rate_scale_pos = 6;
   localparam int stat_busy_pos = 0;
   localparam int stat_arb_pos = 1;
   localparam int stat_master_pos = 2;
   localparam logic [7:0] rate_div_reset = 8'h00;
   localparam logic [7:0] bus_control_reset = 8'h00;
   localparam int div_w = 12;
   localparam int hold_w = 10;
   localparam int half_w = 13;
   localparam logic [div_w-1:0] scl_div_tab [0:63] = '{
      12'h014, 12'h016, 12'h018, 12'h01a, 12'h01c, 12'h01e, 12'h022, 12'h028,
      12'h01c, 12'h020, 12'h024, 12'h028, 12'h02c, 12'h030, 12'h038, 12'h044,
      12'h030, 12'h038, 12'h040, 12'h048, 12'h050, 12'h058, 12'h068, 12'h080,
      12'h050, 12'h060, 12'h070, 12'h080, 12'h090, 12'h0a0, 12'h0c0, 12'h0f0,
      12'h0a0, 12'h0c0, 12'h0e0, 12'h100, 12'h120, 12'h140, 12'h180, 12'h1e0,
      12'h140, 12'h180, 12'h1c0, 12'h200, 12'h240, 12'h280, 12'h300, 12'h3c0,
      12'h280, 12'h300, 12'h380, 12'h400, 12'h480, 12'h500, 12'h600, 12'h780,
      12'h500, 12'h600, 12'h700, 12'h800, 12'h900, 12'ha00, 12'hc00, 12'hf00};
   localparam logic [hold_w-1:0] sda_hold_tab [0:63] = '{
      10'h007, 10'h007, 10'h008, 10'h008, 10'h009, 10'h009, 10'h00a, 10'h00a,
      10'h007, 10'h007, 10'h009, 10'h009, 10'h00b, 10'h00b, 10'h00d, 10'h00d,
      10'h009, 10'h009, 10'h00d, 10'h00d, 10'h011, 10'h011, 10'h015, 10'h015,
      10'h009, 10'h009, 10'h011, 10'h011, 10'h019, 10'h019, 10'h021, 10'h021,
      10'h011, 10'h011, 10'h021, 10'h021, 10'h031, 10'h031, 10'h041, 10'h041,
      10'h021, 10'h021, 10'h041, 10'h041, 10'h061, 10'h061, 10'h081, 10'h081,
      10'h041, 10'h041, 10'h081, 10'h081, 10'h0c1, 10'h0c1, 10'h101, 10'h101,
      10'h081, 10'h081, 10'h101, 10'h101, 10'h181, 10'h181, 10'h201, 10'h201};
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_start = 3'h1,
      st_run = 3'h3,
      st_stop_low = 3'h2,
      st_stop_high = 3'h6,
      st_rs_rel = 3'h7,
      st_rs_high = 3'h5
   } line_state_e;
   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_s;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;
endpackage

// ### hw/i2c_rate_ctrl.sv
// Rate divider, control register and line driver of the two-wire bus controller
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
module i2c_rate_ctrl
   import i2c_rate_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire apb_req_s apb_req,
   output apb_rsp_s apb_rsp,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic tx_bit,
   input wire logic ack_slot,
   input wire logic irq_event,
   output logic scl_fall_seen,
   output logic transmit_mode,
   output logic irq_req
);

   typedef struct packed {
      logic [7:0] rate;
      logic [7:0] ctrl;
      logic arb_lost;
      logic busy;
      line_state_e st;
      logic [half_w-1:0] cnt;
      logic [hold_w-1:0] hold_cnt;
      logic hold_act;
      logic stop_pend;
      logic rs_pend;
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      logic scl_oe_n;
      logic sda_oe_n;
      logic pin_lvl;
      logic scl_fall_p;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ctrl_state_s;

   ctrl_state_s st_r;
   ctrl_state_s st_nxt;
   logic en;
   logic master_bit;
   logic tx_mode;
   logic [div_w-1:0] div_val;
   logic [hold_w-1:0] hold_val;
   logic [13:0] period;
   logic [half_w-1:0] half;
   logic tick;
   logic scl_fall;
   logic scl_rise;
   logic start_seen;
   logic stop_seen;
   logic drive_low;
   logic access;
   logic commit;
   logic [7:0] wbyte;
   logic [7:0] status;

   always_comb begin
      st_nxt = st_r;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.scl_fall_p = 1'b0;
      st_nxt.scl_s1 = scl_i;
      st_nxt.scl_s2 = st_r.scl_s1;
      st_nxt.scl_d = st_r.scl_s2;
      st_nxt.sda_s1 = sda_i;
      st_nxt.sda_s2 = st_r.sda_s1;
      st_nxt.sda_d = st_r.sda_s2;
      en = st_r.ctrl[ctl_enable_pos];
      master_bit = st_r.ctrl[ctl_master_pos];
      tx_mode = st_r.ctrl[ctl_tx_pos];
      div_val = scl_div_tab[st_r.rate[5:0]];
      hold_val = sda_hold_tab[st_r.rate[5:0]];
      // Reserved scale code falls back to factor 1 rather than stopping the clock
      unique case (st_r.rate[7:rate_scale_pos])
         2'b01: period = {1'b0, div_val, 1'b0};
         2'b10: period = {div_val, 2'b00};
         default: period = {2'b00, div_val};
      endcase
      // Every divider is even, so half a period is exact
      half = period[13:1];
      // Edges are taken from the synchronised copies only
      scl_fall = en & st_r.scl_d & ~st_r.scl_s2;
      scl_rise = en & ~st_r.scl_d & st_r.scl_s2;
      start_seen = en & st_r.scl_s2 & st_r.scl_d & st_r.sda_d & ~st_r.sda_s2;
      stop_seen = en & st_r.scl_s2 & st_r.scl_d & ~st_r.sda_d & st_r.sda_s2;
      status = {5'h00, st_r.st != st_idle, st_r.arb_lost, st_r.busy};
      st_nxt.scl_fall_p = scl_fall;

      if (start_seen) begin
         st_nxt.busy = 1'b1;
      end else if (stop_seen) begin
         st_nxt.busy = 1'b0;
      end

      // Half-period divider; a slave holding SCL low stretches the count
      tick = 1'b0;
      if (st_r.st == st_idle) begin
         st_nxt.cnt = half_w'(half - 13'h1);
      end else if (st_r.scl_oe_n && !st_r.scl_s2) begin
         st_nxt.cnt = half_w'(half - 13'h1);
      end else if (st_r.cnt == '0) begin
         tick = 1'b1;
         st_nxt.cnt = half_w'(half - 13'h1);
      end else begin
         st_nxt.cnt = half_w'(st_r.cnt - 13'h1);
      end

      // Data level for the slot now starting; receivers release SDA outside acknowledge
      if (ack_slot) begin
         drive_low = ~tx_mode & ~st_r.ctrl[ctl_ack_pos];
      end else begin
         drive_low = tx_mode & ~tx_bit;
      end

      if (scl_fall) begin
         st_nxt.hold_act = 1'b1;
         st_nxt.hold_cnt = hold_val;
      end else if (st_r.hold_act) begin
         if (st_r.hold_cnt <= 10'h001) begin
            st_nxt.hold_act = 1'b0;
            if (st_r.st == st_idle || st_r.st == st_run) begin
               st_nxt.sda_oe_n = ~drive_low;
            end
         end else begin
            st_nxt.hold_cnt = hold_w'(st_r.hold_cnt - 10'h001);
         end
      end

      // APB: first access cycle prepares the answer, the pready cycle commits a write
      access = apb_req.psel & apb_req.penable;
      commit = access & st_r.pready & apb_req.pwrite;
      wbyte = apb_req.pwdata[7:0];
      if (access && !st_r.pready) begin
         st_nxt.pready = 1'b1;
         st_nxt.prdata = 32'h0000_0000;
         unique case (apb_req.paddr)
            rate_div_offs: st_nxt.prdata = {24'h000000, st_r.rate};
            bus_control_offs: st_nxt.prdata = {24'h000000, st_r.ctrl};
            status_offs: st_nxt.prdata = {24'h000000, status};
            decode_offs: st_nxt.prdata = {6'h00, hold_val, 4'h0, div_val};
            default: st_nxt.pslverr = 1'b1;
         endcase
      end
      if (commit && apb_req.paddr == rate_div_offs) begin
         st_nxt.rate = wbyte;
      end
      if (commit && apb_req.paddr == status_offs && wbyte[stat_arb_pos]) begin
         st_nxt.arb_lost = 1'b0;
      end
      if (commit && apb_req.paddr == bus_control_offs) begin
         st_nxt.ctrl = wbyte;
         st_nxt.ctrl[ctl_repeat_start_request_pos] = 1'b0;
         if (wbyte[ctl_master_pos] && !master_bit) begin
            if (st_r.busy || st_r.st != st_idle || !wbyte[ctl_enable_pos]) begin
               st_nxt.arb_lost = 1'b1;
               st_nxt.ctrl[ctl_master_pos] = 1'b0;
            end else begin
               st_nxt.st = st_start;
               st_nxt.sda_oe_n = 1'b0;
               st_nxt.scl_oe_n = 1'b1;
            end
         end else if (!wbyte[ctl_master_pos] && master_bit && st_r.st != st_idle) begin
            st_nxt.stop_pend = 1'b1;
         end
         if (wbyte[ctl_repeat_start_request_pos]) begin
            if (master_bit && wbyte[ctl_master_pos] && st_r.st == st_run) begin
               st_nxt.rs_pend = 1'b1;
            end else begin
               st_nxt.arb_lost = 1'b1;
            end
         end
      end

      // Line sequencer; hardware sets after the software clear so the set wins
      unique case (st_r.st)
         st_idle: begin
         end
         st_start: begin
            if (tick) begin
               st_nxt.st = st_run;
               st_nxt.scl_oe_n = 1'b0;
            end
         end
         st_run: begin
            if (scl_rise && tx_mode && !ack_slot && st_r.sda_oe_n && !st_r.sda_s2) begin
               // Another master won the bit: fall back to slave without a STOP
               st_nxt.st = st_idle;
               st_nxt.scl_oe_n = 1'b1;
               st_nxt.sda_oe_n = 1'b1;
               st_nxt.arb_lost = 1'b1;
               st_nxt.stop_pend = 1'b0;
               st_nxt.rs_pend = 1'b0;
               st_nxt.ctrl[ctl_master_pos] = 1'b0;
            end else if (tick && st_r.scl_oe_n) begin
               st_nxt.scl_oe_n = 1'b0;
            end else if (tick && st_r.stop_pend) begin
               st_nxt.st = st_stop_low;
               st_nxt.sda_oe_n = 1'b0;
               st_nxt.stop_pend = 1'b0;
               st_nxt.rs_pend = 1'b0;
            end else if (tick && st_r.rs_pend) begin
               st_nxt.st = st_rs_rel;
               st_nxt.sda_oe_n = 1'b1;
               st_nxt.rs_pend = 1'b0;
            end else if (tick) begin
               st_nxt.scl_oe_n = 1'b1;
            end
         end
         st_stop_low: begin
            if (tick) begin
               st_nxt.st = st_stop_high;
               st_nxt.scl_oe_n = 1'b1;
            end
         end
         st_stop_high: begin
            if (tick) begin
               st_nxt.st = st_idle;
               st_nxt.sda_oe_n = 1'b1;
            end
         end
         st_rs_rel: begin
            if (tick) begin
               st_nxt.st = st_rs_high;
               st_nxt.scl_oe_n = 1'b1;
            end
         end
         st_rs_high: begin
            if (tick) begin
               st_nxt.st = st_start;
               st_nxt.sda_oe_n = 1'b0;
            end
         end
         default: begin
            st_nxt.st = st_idle;
            st_nxt.scl_oe_n = 1'b1;
            st_nxt.sda_oe_n = 1'b1;
         end
      endcase

      // Disabled: everything quiet and both lines released
      // Uses the next enable so one write can enable the module and start at once
      if (!st_nxt.ctrl[ctl_enable_pos]) begin
         st_nxt.st = st_idle;
         st_nxt.scl_oe_n = 1'b1;
         st_nxt.sda_oe_n = 1'b1;
         st_nxt.busy = 1'b0;
         st_nxt.hold_act = 1'b0;
         st_nxt.stop_pend = 1'b0;
         st_nxt.rs_pend = 1'b0;
      end

      st_nxt.irq = en & st_r.ctrl[ctl_irq_en_pos] & (irq_event | st_r.arb_lost);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= '0;
         st_r.rate <= rate_div_reset;
         st_r.ctrl <= bus_control_reset;
         st_r.st <= st_idle;
         st_r.scl_s1 <= 1'b1;
         st_r.scl_s2 <= 1'b1;
         st_r.scl_d <= 1'b1;
         st_r.sda_s1 <= 1'b1;
         st_r.sda_s2 <= 1'b1;
         st_r.sda_d <= 1'b1;
         st_r.scl_oe_n <= 1'b1;
         st_r.sda_oe_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign apb_rsp.prdata = st_r.prdata;
   assign apb_rsp.pready = st_r.pready;
   assign apb_rsp.pslverr = st_r.pslverr;
   assign scl_o = st_r.pin_lvl;
   assign sda_o = st_r.pin_lvl;
   assign scl_oe_n = st_r.scl_oe_n;
   assign sda_oe_n = st_r.sda_oe_n;
   assign scl_fall_seen = st_r.scl_fall_p;
   assign transmit_mode = st_r.ctrl[ctl_tx_pos];
   assign irq_req = st_r.irq;

endmodule // i2c_rate_ctrl

// ### test/i2c_rate_ctrl_sva.sv
// Port assertions for the rate divider and control block
module i2c_rate_ctrl_sva
   import i2c_rate_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire apb_req_s apb_req,
   input wire apb_rsp_s apb_rsp,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_n,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic irq_event,
   input wire logic scl_fall_seen,
   input wire logic transmit_mode,
   input wire logic irq_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl_r;
   // Shadow of written control bits; refusals may clear master, so bit 5 is not trusted
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl_r <= 8'h00;
      end else if (apb_rsp.pready && apb_req.pwrite && apb_req.paddr == bus_control_offs) begin
         ctl_r <= apb_req.pwdata[7:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_one_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
      else $error("pready not one cycle after access");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready longer than one cycle");
   a_unmapped_err: assert property (apb_rsp.pready && apb_req.paddr > decode_offs |-> apb_rsp.pslverr
      && apb_rsp.prdata == 32'h0) else $error("unmapped access not refused");
   a_repeat_start_request_reads_low: assert property (apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == bus_control_offs
      |-> !apb_rsp.prdata[ctl_repeat_start_request_pos]) else $error("repeat start bit read high");
   a_tx_follows: assert property ($stable(ctl_r[ctl_tx_pos]) |-> transmit_mode == ctl_r[ctl_tx_pos])
      else $error("direction output wrong");
   a_irq_gated: assert property (irq_req |-> $past(ctl_r[7] && ctl_r[6]) || (ctl_r[7] && ctl_r[6]))
      else $error("interrupt request while gated");
   a_irq_raise: assert property (ctl_r[7] && ctl_r[6] && irq_event |=> irq_req)
      else $error("interrupt request missing");
   a_off_released: assert property (!ctl_r[7] && $past(!ctl_r[7], 2) |-> scl_oe_n && sda_oe_n
      && !scl_fall_seen) else $error("disabled module active on lines");
   a_od_low: assert property (!scl_o && !sda_o) else $error("open drain value not low");
   a_start_scl_high: assert property ($fell(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |=> scl_oe_n[*8])
      else $error("SCL pulled too soon after start");
   a_fall_seen: assert property (ctl_r[7] && $fell(scl_i) |-> ##[1:4] scl_fall_seen)
      else $error("falling SCL not flagged");
endmodule // i2c_rate_ctrl_sva

// ### test/i2c_line_model.sv
// Pulled-up bus lines with a far-side slave that can stretch SCL
module i2c_line_model
(
   input wire logic clk,
   input wire logic scl_oe_n,
   input wire logic sda_oe_n,
   input wire logic stretch,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   int hold_left = 0;
   // A slow slave keeps SCL low four cycles after the master lets go
   always @(posedge clk) begin
      if (!scl_oe_n) begin
         hold_left <= stretch ? 4 : 0;
      end else if (hold_left > 0) begin
         hold_left <= hold_left - 1;
      end
   end
   assign scl = scl_oe_n && hold_left == 0;
   assign sda = sda_oe_n;
endmodule // i2c_line_model

// ### test/testbench.sv
// Self-checking bench for the rate divider and control block
module testbench
   import i2c_rate_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset = 1, scl_i, sda_i, scl_o, scl_oe_n, sda_o, sda_oe_n;
   logic tx_bit = 1, ack_slot = 0, irq_event = 0, stretch = 0, scl_fall_seen, transmit_mode, irq_req, err;
   apb_req_s apb_req = '0;
   apb_rsp_s apb_rsp;
   logic [31:0] rd;
   int num_errors = 0, total_checks = 0, seed = 22238;
   int dv[32] = '{20, 22, 24, 26, 28, 30, 34, 40, 28, 32, 36, 40, 44, 48, 56, 68, 48, 56, 64, 72, 80, 88, 104,
      128, 80, 96, 112, 128, 144, 160, 192, 240};
   int hv[32] = '{7, 7, 8, 8, 9, 9, 10, 10, 7, 7, 9, 9, 11, 11, 13, 13, 9, 9, 13, 13, 17, 17, 21, 21, 9, 9, 17,
      17, 25, 25, 33, 33};
   always #4 clk = ~clk;
   i2c_rate_ctrl i_dut(
      .clk(clk),
      .reset(reset),
      .apb_req(apb_req),
      .apb_rsp(apb_rsp),
      .scl_i(scl_i),
      .scl_o(scl_o),
      .scl_oe_n(scl_oe_n),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_n(sda_oe_n),
      .tx_bit(tx_bit),
      .ack_slot(ack_slot),
      .irq_event(irq_event),
      .scl_fall_seen(scl_fall_seen),
      .transmit_mode(transmit_mode),
      .irq_req(irq_req));
   i2c_line_model i_bus(.clk(clk), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .stretch(stretch), .scl(scl_i),
      .sda(sda_i));
   // Upper code groups scale the fourth group by powers of two
   function automatic logic [31:0] dec_exp(input int c);
      int s, i;
      s = c < 32 ? 0 : c / 8 - 3;
      i = c < 32 ? c : 24 + c % 8;
      return {6'h0, 10'((hv[i] << s) - (1 << s) + 1), 4'h0, 12'(dv[i] << s)};
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Waits for pready however long it takes; only the watchdog ends a hung transfer
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      apb_req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   // Counts settled cycles until the chosen enable (0 SCL, 1 SDA) reaches v
   task automatic waitfor(input logic w, input logic v, output int n);
      n = 0;
      #1;
      while ((w ? sda_oe_n : scl_oe_n) !== v) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic run_master(input logic [1:0] sc, input int ex);
      int h, n1, n2, n3;
      h = 10 << sc;
      apb(rate_div_offs, 1'b1, {24'h0, sc, 6'h00});
      apb(bus_control_offs, 1'b1, 32'hb0);
      waitfor(1'b1, 1'b0, n1);
      check(n1, 0);
      waitfor(1'b0, 1'b0, n1);
      check(32'(n1 >= h - 1 && n1 <= h + 2), 1);
      waitfor(1'b1, 1'b1, n2);
      check(32'(n2 >= 7 && n2 <= 11), 1);
      waitfor(1'b0, 1'b1, n3);
      waitfor(1'b0, 1'b0, n1);
      check(32'(n1 + n2 + n3 >= 2 * h + ex && n1 + n2 + n3 <= 2 * h + ex + 5), 1);
      // Acknowledge is driven only as receiver, so switch to receive first
      @(posedge clk);
      ack_slot <= 1'b1;
      apb(bus_control_offs, 1'b1, 32'ha0);
      waitfor(1'b1, 1'b0, n1);
      check(32'(n1 < 4 * h), 1);
      apb(bus_control_offs, 1'b1, 32'ha8);
      waitfor(1'b1, 1'b1, n1);
      check(32'(n1 < 4 * h), 1);
      @(posedge clk);
      ack_slot <= 1'b0;
      apb(bus_control_offs, 1'b1, 32'hb4);
      apb(status_offs, 1'b0, 32'h0);
      check(rd[2:1], 2'b10);
      apb(bus_control_offs, 1'b0, 32'h0);
      check(rd[7:0], 8'hb0);
      waitfor(1'b1, 1'b1, n1);
      waitfor(1'b1, 1'b0, n1);
      check(scl_oe_n, 1'b1);
      waitfor(1'b0, 1'b0, n1);
      apb(bus_control_offs, 1'b1, 32'h80);
      waitfor(1'b0, 1'b1, n1);
      check(sda_oe_n, 1'b0);
      waitfor(1'b1, 1'b1, n2);
      check(32'(n2 >= h - 1 && n2 <= h + ex + 4 && scl_oe_n), 1);
   endtask
   initial begin
      #400000;
      num_errors++;
      wrap_up;
   end
   initial begin
      logic [31:0] v;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      apb(rate_div_offs, 1'b0, 32'h0);
      check(rd, 32'h0);
      apb(bus_control_offs, 1'b0, 32'h0);
      check(rd, 32'h0);
      apb(8'h10, 1'b1, 32'hff);
      check(err, 1'b1);
      check(rd, 32'h0);
      for (int c = 0; c < 64; c++) begin
         v = $random(seed);
         apb(rate_div_offs, 1'b1, {24'h0, v[1:0], 6'(c)});
         apb(decode_offs, 1'b0, 32'h0);
         check(rd, dec_exp(c));
         apb(rate_div_offs, 1'b0, 32'h0);
         check(rd, {24'h0, v[1:0], 6'(c)});
      end
      apb(bus_control_offs, 1'b1, 32'h24);
      apb(status_offs, 1'b0, 32'h0);
      check(rd[1], 1'b1);
      apb(bus_control_offs, 1'b0, 32'h0);
      check(rd[7:0], 8'h00);
      apb(bus_control_offs, 1'b1, 32'hc0);
      repeat (2) @(posedge clk);
      check(irq_req, 1'b1);
      apb(status_offs, 1'b1, 32'h2);
      apb(status_offs, 1'b0, 32'h0);
      check(rd[1], 1'b0);
      for (int i = 0; i < 12; i++) begin
         v = $random(seed);
         irq_event <= v[0];
         // Direction follows a random slave read/write status, as software must do
         apb(bus_control_offs, 1'b1, {24'h0, v[7:6], 1'b0, v[4], 4'h0});
         repeat (2) @(posedge clk);
         check(irq_req, v[7] & v[6] & v[0]);
         check(transmit_mode, v[4]);
      end
      irq_event <= 1'b0;
      run_master(2'b00, 0);
      stretch <= 1'b1;
      run_master(2'b01, 4);
      wrap_up;
   end
endmodule // testbench
bind i2c_rate_ctrl i2c_rate_ctrl_sva i_sva(
   .clk(clk),
   .reset(reset),
   .apb_req(apb_req),
   .apb_rsp(apb_rsp),
   .scl_i(scl_i),
   .scl_o(scl_o),
   .scl_oe_n(scl_oe_n),
   .sda_o(sda_o),
   .sda_oe_n(sda_oe_n),
   .irq_event(irq_event),
   .scl_fall_seen(scl_fall_seen),
   .transmit_mode(transmit_mode),
   .irq_req(irq_req));
